//--- common/pme_wake_regs.svh
`ifndef PME_WAKE_REGS_SVH
`define PME_WAKE_REGS_SVH
`define PMC_ADDR_CTRL      8'h84
`define PMC_ADDR_CONFIG    8'h74
`define PMC_BIT_READY      0
`define PMC_BIT_OUT_EN     1
`define PMC_BIT_POL        2
`define PMC_BIT_PULSE      3
`define PMC_CAUSE_LO       4
`define PMC_CAUSE_HI       5
`define PMC_BIT_DRIVE      6
`define PMC_BIT_ENERGY_EN  8
`define PMC_BIT_FRAME_EN   9
`define PMC_MODE_LO        12
`define PMC_MODE_HI        13
`define PMC_WMASK          32'h0000337E
`define PMC_PULSE_MS       50
`define PMC_CLK_HZ         50000000
`define PMC_READY_CYCLES   16
`define CMD_ADDR_CTRL      4'h0
`define CMD_ADDR_STATUS    4'h4
`define CMD_ADDR_RDATA     4'h8
`endif

//--- common/pme_wake_pkg.sv
package pme_wake_pkg;
  typedef logic [1:0]  wake_cause_t;
  typedef logic [1:0]  power_state_t;
  typedef logic [31:0] word_t;
  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_REQ   = 4'b0010,
    H_WAIT  = 4'b0100,
    H_DONE  = 4'b1000
  } host_state_e;
endpackage

//--- common/pme_wake_if.sv
`timescale 1ns/1ps
interface pme_wake_if;
  logic [7:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        ack;
  logic        pme_o;
  logic        pme_oe;
  logic        irq;
  modport device (input addr, input rd, input wr, input wdata,
                  output rdata, output ack, output pme_o, output pme_oe, output irq);
  modport host (output addr, output rd, output wr, output wdata,
                input rdata, input ack, input pme_o, input pme_oe, input irq);
endinterface

//--- rtl/pme_wake_dev.sv
`timescale 1ns/1ps
`include "pme_wake_regs.svh"
module pme_wake_dev #(
  parameter int CLK_HZ       = `PMC_CLK_HZ,
  parameter int PULSE_MS     = `PMC_PULSE_MS,
  parameter int READY_CYCLES = `PMC_READY_CYCLES
) (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  // link to host
  pme_wake_if.device       LNK,
  // event sources, pin domain
  input  wire logic        ENERGY_EVT,
  input  wire logic        FRAME_EVT,
  input  wire logic        WAKE_REQ,
  // state seen by the rest of the chip
  output pme_wake_pkg::power_state_t POWER_STATE
);
  import pme_wake_pkg::*;

  localparam int PULSE_CYC = (CLK_HZ / 1000) * PULSE_MS;
  localparam int TW = $clog2(PULSE_CYC + 1);
  localparam int RW = $clog2(READY_CYCLES + 1);

  logic [1:0]   ed_sync_ff, fr_sync_ff, wk_sync_ff;
  logic         ed_prev_ff, fr_prev_ff, wk_prev_ff;
  wake_cause_t  cause_ff;
  power_state_t mode_ff;
  logic         frame_en_ff, energy_en_ff, drive_ff, pulse_ff, pol_ff, oe_en_ff;
  logic         ready_ff;
  logic [RW-1:0] rdy_cnt_ff;
  logic [TW-1:0] pulse_cnt_ff;
  logic         active_ff, irq_ff, pin_o_ff, pin_oe_ff, ack_ff;
  word_t        rdata_ff;
  logic         ed_rise, fr_rise, wk_rise, ed_hit, fr_hit, wake_evt;
  logic         ctrl_wr;
  word_t        ctrl_word;

  // two-flop synchronisers; only the second stage feeds logic
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ed_sync_ff <= 2'h0;
      fr_sync_ff <= 2'h0;
      wk_sync_ff <= 2'h0;
    end else begin
      ed_sync_ff <= {ed_sync_ff[0], ENERGY_EVT};
      fr_sync_ff <= {fr_sync_ff[0], FRAME_EVT};
      wk_sync_ff <= {wk_sync_ff[0], WAKE_REQ};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ed_prev_ff <= 1'b0;
      fr_prev_ff <= 1'b0;
      wk_prev_ff <= 1'b0;
    end else begin
      ed_prev_ff <= ed_sync_ff[1];
      fr_prev_ff <= fr_sync_ff[1];
      wk_prev_ff <= wk_sync_ff[1];
    end
  end

  // energy and frame detectors act only in their own power mode; wake request acts in any
  assign ed_rise  = ed_sync_ff[1] & ~ed_prev_ff;
  assign fr_rise  = fr_sync_ff[1] & ~fr_prev_ff;
  assign wk_rise  = wk_sync_ff[1] & ~wk_prev_ff;
  assign ed_hit   = ed_rise & energy_en_ff & (mode_ff == 2'h2);
  assign fr_hit   = fr_rise & frame_en_ff & (mode_ff == 2'h1);
  assign wake_evt = ed_hit | fr_hit;
  assign ctrl_wr  = LNK.wr & ~ack_ff & (LNK.addr == `PMC_ADDR_CTRL);

  // cause field; set wins over clear
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      cause_ff <= 2'h0;
    end else begin
      if (ctrl_wr && ready_ff) begin
        if (LNK.wdata[`PMC_CAUSE_LO] && !ed_sync_ff[1]) begin
          cause_ff[0] <= 1'b0;
        end
        if (LNK.wdata[`PMC_CAUSE_HI] && !fr_sync_ff[1]) begin
          cause_ff[1] <= 1'b0;
        end
      end
      if (ed_hit) begin
        cause_ff[0] <= 1'b1;
      end
      if (fr_hit) begin
        cause_ff[1] <= 1'b1;
      end
    end
  end

  // writable control fields
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      frame_en_ff  <= 1'b0;
      energy_en_ff <= 1'b0;
      drive_ff  <= 1'b0;
      pulse_ff  <= 1'b0;
      pol_ff    <= 1'b0;
      oe_en_ff  <= 1'b0;
    end else if (ctrl_wr) begin
      frame_en_ff  <= LNK.wdata[`PMC_BIT_FRAME_EN];
      energy_en_ff <= LNK.wdata[`PMC_BIT_ENERGY_EN];
      drive_ff  <= LNK.wdata[`PMC_BIT_DRIVE];
      pulse_ff  <= LNK.wdata[`PMC_BIT_PULSE];
      pol_ff    <= LNK.wdata[`PMC_BIT_POL];
      oe_en_ff  <= LNK.wdata[`PMC_BIT_OUT_EN];
    end
  end

  // power mode: host sets, a wake event or wake request returns to normal
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      mode_ff <= 2'h0;
    end else if (wake_evt || wk_rise) begin
      mode_ff <= 2'h0;
    end else if (ctrl_wr && LNK.wdata[`PMC_MODE_HI:`PMC_MODE_LO] != 2'h3) begin
      mode_ff <= LNK.wdata[`PMC_MODE_HI:`PMC_MODE_LO];
    end
  end

  // ready after a settle time in normal mode, cleared in reduced modes
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rdy_cnt_ff <= '0;
      ready_ff   <= 1'b0;
    end else if (mode_ff != 2'h0) begin
      rdy_cnt_ff <= '0;
      ready_ff   <= 1'b0;
    end else if (rdy_cnt_ff == RW'(READY_CYCLES)) begin
      ready_ff   <= 1'b1;
    end else begin
      rdy_cnt_ff <= rdy_cnt_ff + RW'(1);
    end
  end

  // event indication: pulse timer or static hold
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      active_ff    <= 1'b0;
      pulse_cnt_ff <= '0;
    end else if (wake_evt) begin
      active_ff    <= 1'b1;
      pulse_cnt_ff <= TW'(PULSE_CYC);
    end else if (cause_ff == 2'h0 || !(frame_en_ff || energy_en_ff)) begin
      active_ff    <= 1'b0;
      pulse_cnt_ff <= '0;
    end else if (pulse_ff && active_ff) begin
      if (pulse_cnt_ff <= TW'(1)) begin
        active_ff <= 1'b0;
      end
      pulse_cnt_ff <= (pulse_cnt_ff == '0) ? '0 : pulse_cnt_ff - TW'(1);
    end
  end

  // pin driver with polarity (push-pull only, open drain always pulls low), drive type and enable
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      pin_o_ff  <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else if (!drive_ff) begin
      pin_o_ff  <= 1'b0;
      pin_oe_ff <= oe_en_ff & active_ff;
    end else begin
      pin_o_ff  <= pol_ff ? active_ff : ~active_ff;
      pin_oe_ff <= oe_en_ff;
    end
  end

  // internal interrupt follows the cause field whatever the pin enable
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (cause_ff != 2'h0) | wake_evt;
    end
  end

  // register read mux
  always_comb begin
    ctrl_word = '0;
    ctrl_word[`PMC_BIT_READY] = ready_ff;
    ctrl_word[`PMC_BIT_OUT_EN] = oe_en_ff;
    ctrl_word[`PMC_BIT_POL] = pol_ff;
    ctrl_word[`PMC_BIT_PULSE] = pulse_ff;
    ctrl_word[`PMC_CAUSE_HI:`PMC_CAUSE_LO] = cause_ff;
    ctrl_word[`PMC_BIT_DRIVE] = drive_ff;
    ctrl_word[`PMC_BIT_ENERGY_EN] = energy_en_ff;
    ctrl_word[`PMC_BIT_FRAME_EN] = frame_en_ff;
    ctrl_word[`PMC_MODE_HI:`PMC_MODE_LO] = mode_ff;
  end

  // one-cycle acknowledge; control readable in every mode
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ack_ff   <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff <= (LNK.rd | LNK.wr) & ~ack_ff;
      if (LNK.rd && !ack_ff) begin
        rdata_ff <= (LNK.addr == `PMC_ADDR_CTRL) ? ctrl_word : '0;
      end
    end
  end

  assign LNK.ack    = ack_ff;
  assign LNK.rdata  = rdata_ff;
  assign LNK.pme_o  = pin_o_ff;
  assign LNK.pme_oe = pin_oe_ff;
  assign LNK.irq    = irq_ff;
  assign POWER_STATE = mode_ff;
endmodule

//--- rtl/pme_wake_host.sv
`timescale 1ns/1ps
`include "pme_wake_regs.svh"
module pme_wake_host (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  // link to device
  pme_wake_if.host         LNK,
  // avalon-mm slave
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // event pin level and interrupt seen by host
  output logic             EVENT_SEEN,
  output logic             IRQ_SEEN
);
  import pme_wake_pkg::*;

  host_state_e st_ff;
  logic [7:0]  cmd_addr_ff;
  logic        cmd_rd_ff, cmd_go_ff, ready_seen_ff, refused_ff;
  word_t       cmd_wdata_ff, link_rdata_ff, rdata_ff;
  logic        l_rd_ff, l_wr_ff, wait_ff, ev_ff, irq_ff;
  logic        pin_level;
  logic        access_ok;

  // resolved pin level: undriven line pulled high
  assign pin_level = LNK.pme_oe ? LNK.pme_o : 1'b1;
  assign access_ok = (cmd_addr_ff == `PMC_ADDR_CTRL) ||
                     (ready_seen_ff) ||
                     (cmd_rd_ff && cmd_addr_ff == `PMC_ADDR_CONFIG);

  // avalon slave: one wait cycle then answer
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      wait_ff      <= 1'b1;
      rdata_ff     <= '0;
      cmd_addr_ff  <= 8'h0;
      cmd_wdata_ff <= '0;
      cmd_rd_ff    <= 1'b0;
      cmd_go_ff    <= 1'b0;
    end else begin
      wait_ff   <= 1'b1;
      cmd_go_ff <= 1'b0;
      // read data taken on the accepting edge, standing while waitrequest is low
      if ((AVS_READ || AVS_WRITE) && wait_ff) begin
        wait_ff <= 1'b0;
        case (AVS_ADDRESS)
          `CMD_ADDR_CTRL:   rdata_ff <= {16'h0, cmd_addr_ff, 6'h0, refused_ff, cmd_rd_ff};
          `CMD_ADDR_STATUS: rdata_ff <= {28'h0, irq_ff, ev_ff, ready_seen_ff, st_ff != H_IDLE};
          `CMD_ADDR_RDATA:  rdata_ff <= link_rdata_ff;
          default:          rdata_ff <= '0;
        endcase
      end
      // a write lands only on the edge that completes the transfer
      if (AVS_WRITE && !wait_ff) begin
        case (AVS_ADDRESS)
          `CMD_ADDR_CTRL: begin
            cmd_addr_ff <= AVS_WRITEDATA[15:8];
            cmd_rd_ff   <= AVS_WRITEDATA[0];
            cmd_go_ff   <= AVS_WRITEDATA[1];
          end
          `CMD_ADDR_RDATA: cmd_wdata_ff <= AVS_WRITEDATA;
          default:         cmd_go_ff <= 1'b0;
        endcase
      end
    end
  end

  // link sequencer
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      st_ff         <= H_IDLE;
      l_rd_ff       <= 1'b0;
      l_wr_ff       <= 1'b0;
      link_rdata_ff <= '0;
      ready_seen_ff <= 1'b0;
      refused_ff    <= 1'b0;
    end else begin
      case (st_ff)
        H_IDLE: begin
          if (cmd_go_ff) begin
            st_ff <= H_REQ;
          end
        end
        H_REQ: begin
          if (access_ok) begin
            refused_ff <= 1'b0;
            l_rd_ff    <= cmd_rd_ff;
            l_wr_ff    <= ~cmd_rd_ff;
            st_ff      <= H_WAIT;
          end else begin
            refused_ff <= 1'b1;
            st_ff      <= H_IDLE;
          end
        end
        H_WAIT: begin
          if (LNK.ack) begin
            l_rd_ff <= 1'b0;
            l_wr_ff <= 1'b0;
            st_ff   <= H_DONE;
          end
        end
        H_DONE: begin
          link_rdata_ff <= LNK.rdata;
          if (l_rd_ff == 1'b0 && cmd_rd_ff && cmd_addr_ff == `PMC_ADDR_CTRL) begin
            ready_seen_ff <= LNK.rdata[`PMC_BIT_READY];
          end
          st_ff <= H_IDLE;
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end

  // sampled indications
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ev_ff  <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      ev_ff  <= pin_level;
      irq_ff <= LNK.irq;
    end
  end

  assign LNK.addr        = cmd_addr_ff;
  assign LNK.rd          = l_rd_ff;
  assign LNK.wr          = l_wr_ff;
  assign LNK.wdata       = cmd_wdata_ff;
  assign AVS_READDATA    = rdata_ff;
  assign AVS_WAITREQUEST = wait_ff;
  assign EVENT_SEEN      = ev_ff;
  assign IRQ_SEEN        = irq_ff;
endmodule

//--- testbench/pme_wake_props.sv
`timescale 1ns/1ps
module pme_wake_props #(
  parameter int READY_CYCLES = 16,
  parameter int PULSE_CYC    = 1000
) (
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        SYS_RST,
  // link signals
  input wire logic [7:0]  addr,
  input wire logic        rd,
  input wire logic        wr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        ack,
  input wire logic        pme_o,
  input wire logic        pme_oe,
  input wire logic        irq
);
  logic [5:0]  cfg_ff;
  logic [3:0]  age_ff;
  logic [7:0]  since_ff;
  logic [15:0] act_cnt_ff;
  logic        slept_ff;
  logic        ctrl_wr;
  logic        act;
  logic        pp_static;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // control writes and pin activity
  assign ctrl_wr = wr && ack && addr == 8'h84;
  assign act = cfg_ff[3] ? pme_oe && pme_o == cfg_ff[1] : pme_oe;
  assign pp_static = age_ff == 4'hF && cfg_ff[0] && cfg_ff[3] && !cfg_ff[2] && |cfg_ff[5:4];
  // shadow of enables, drive, pulse, polarity
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      cfg_ff <= 6'h0;
      age_ff <= 4'h0;
      slept_ff <= 1'b0;
    end else if (ctrl_wr) begin
      cfg_ff <= {wdata[9:8], wdata[6], wdata[3:1]};
      age_ff <= 4'h0;
      slept_ff <= slept_ff || wdata[13:12] != 2'h0;
    end else if (age_ff != 4'hF) begin
      age_ff <= age_ff + 4'h1;
    end
  end
  // cycles since reset and length of active pin
  always_ff @(posedge CLK_SYS) begin
    since_ff <= SYS_RST ? 8'h0 : since_ff + {7'h0, since_ff != 8'hFF};
    act_cnt_ff <= (SYS_RST || !act) ? 16'h0 : act_cnt_ff + 16'h1;
  end
  property p_answer;
    (rd || wr) && !ack |=> ack;
  endproperty
  a_answer: assert property (p_answer) else $error("link request not answered");
  property p_ready_low;
    rd && ack && addr == 8'h84 && since_ff < READY_CYCLES |-> !rdata[0];
  endproperty
  a_ready_low: assert property (p_ready_low) else $error("ready too early");
  property p_ready_high;
    rd && ack && addr == 8'h84 && since_ff > READY_CYCLES + 3 && !slept_ff |-> rdata[0];
  endproperty
  a_ready_high: assert property (p_ready_high) else $error("ready missing");
  property p_static_act;
    pp_static && irq [*3] |-> pme_oe && pme_o == cfg_ff[1];
  endproperty
  a_static_act: assert property (p_static_act) else $error("pin not held active");
  property p_static_idle;
    pp_static && !irq [*3] |-> pme_o == !cfg_ff[1];
  endproperty
  a_static_idle: assert property (p_static_idle) else $error("pin active without cause");
  property p_pulse_len;
    $fell(act) && cfg_ff[2] && irq |-> act_cnt_ff == PULSE_CYC;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
  property p_oe_off;
    ctrl_wr && !wdata[1] |-> ##2 !pme_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven while disabled");
  property p_od_low;
    ctrl_wr && !wdata[6] |-> ##2 !pme_o;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain drives high");
  property p_irq_kept;
    ctrl_wr && !wdata[1] && wdata[5:4] == 2'h0 && irq |-> ##2 irq;
  endproperty
  a_irq_kept: assert property (p_irq_kept) else $error("interrupt lost with pin enable");
endmodule

//--- testbench/pme_wake_indicator_tb.sv
`timescale 1ns/1ps
module pme_wake_indicator_tb;
  import pme_wake_pkg::*;
  localparam int PULSE_CYC = 20000 / 1000 * 50;
  logic         CLK_SYS = 1'b0;
  logic         SYS_RST = 1'b1;
  logic [3:0]   AVS_ADDRESS = 4'h0;
  logic         AVS_READ = 1'b0;
  logic         AVS_WRITE = 1'b0;
  word_t        AVS_WRITEDATA = 32'h0;
  word_t        AVS_READDATA;
  logic         AVS_WAITREQUEST;
  logic         ENERGY_EVT = 1'b0;
  logic         FRAME_EVT = 1'b0;
  logic         WAKE_REQ = 1'b0;
  logic         ev_seen;
  logic         irq_seen;
  power_state_t mode_seen;
  word_t        q;
  int           n_mismatch = 0;
  int           checked = 0;
  pme_wake_if lnk ();
  // free running clock
  always #10 CLK_SYS = ~CLK_SYS;
  pme_wake_dev #(.CLK_HZ(20000), .PULSE_MS(50), .READY_CYCLES(16)) pme_wake_dev_i (.CLK_SYS(CLK_SYS),
    .SYS_RST(SYS_RST), .LNK(lnk.device), .ENERGY_EVT(ENERGY_EVT), .FRAME_EVT(FRAME_EVT), .WAKE_REQ(WAKE_REQ),
    .POWER_STATE(mode_seen));
  pme_wake_host pme_wake_host_i (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .LNK(lnk.host),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .EVENT_SEEN(ev_seen), .IRQ_SEEN(irq_seen));
  pme_wake_props #(.READY_CYCLES(16), .PULSE_CYC(PULSE_CYC)) pme_wake_props_i (.CLK_SYS(CLK_SYS),
    .SYS_RST(SYS_RST), .addr(lnk.addr), .rd(lnk.rd), .wr(lnk.wr), .wdata(lnk.wdata), .rdata(lnk.rdata),
    .ack(lnk.ack), .pme_o(lnk.pme_o), .pme_oe(lnk.pme_oe), .irq(lnk.irq));
  // verdict and end of run
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // compare seen against expected
  task automatic chk(input string what, input word_t seen, input word_t exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one avalon transfer, held until waitrequest low
  task automatic av(input logic w, input logic [3:0] a, input word_t d, output word_t r);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    AVS_ADDRESS <= a;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_WRITEDATA <= d;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 40);
    r = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    if (n >= 40) begin
      n_mismatch++;
      conclude();
    end
  endtask
  // one link access through the host command registers
  task automatic lk(input logic w, input logic [7:0] a, input word_t d, output word_t r);
    word_t s;
    int n;
    if (w) begin
      av(1'b1, 4'h8, d, s);
    end
    av(1'b1, 4'h0, {16'h0, a, 6'h0, 1'b1, !w}, s);
    repeat (3) @(posedge CLK_SYS);
    n = 0;
    s = 32'h1;
    while (s[0] !== 1'b0 && n < 20) begin
      av(1'b0, 4'h4, 32'h0, s);
      n++;
    end
    if (s[0] !== 1'b0) begin
      n_mismatch++;
      conclude();
    end
    av(1'b0, 4'h8, 32'h0, r);
  endtask
  // pin drive, enable and interrupt packed
  function automatic word_t pin();
    return {29'h0, lnk.pme_o, lnk.pme_oe, lnk.irq};
  endfunction
  // main sequence
  initial begin
    repeat (3) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    lk(1'b0, 8'h84, 32'h0, q);
    chk("ready early", q, 32'h0);
    repeat (30) @(posedge CLK_SYS);
    lk(1'b0, 8'h84, 32'h0, q);
    chk("ready", q, 32'h1);
    lk(1'b0, 8'hA0, 32'h0, q);
    chk("unmapped", q, 32'h0);
    lk(1'b1, 8'h84, 32'h2146, q);
    chk("mode", {30'h0, mode_seen}, 32'h2);
    ENERGY_EVT <= 1'b1;
    repeat (30) @(posedge CLK_SYS);
    lk(1'b0, 8'h84, 32'h0, q);
    chk("energy", q, 32'h157);
    chk("pin static", pin(), 32'h7);
    lk(1'b1, 8'h84, 32'h156, q);
    lk(1'b0, 8'h84, 32'h0, q);
    chk("held", q, 32'h157);
    ENERGY_EVT <= 1'b0;
    repeat (4) @(posedge CLK_SYS);
    lk(1'b1, 8'h84, 32'h156, q);
    lk(1'b0, 8'h84, 32'h0, q);
    chk("cleared", q, 32'h147);
    chk("pin off", pin(), 32'h2);
    lk(1'b1, 8'h84, 32'h124A, q);
    FRAME_EVT <= 1'b1;
    repeat (30) @(posedge CLK_SYS);
    lk(1'b0, 8'h84, 32'h0, q);
    chk("frame", q, 32'h26B);
    chk("pulse on", pin(), 32'h3);
    repeat (PULSE_CYC) @(posedge CLK_SYS);
    chk("pulse off", pin(), 32'h7);
    FRAME_EVT <= 1'b0;
    lk(1'b1, 8'h84, 32'h2106, q);
    ENERGY_EVT <= 1'b1;
    repeat (30) @(posedge CLK_SYS);
    lk(1'b0, 8'h84, 32'h0, q);
    chk("both", q, 32'h137);
    chk("open drain", pin(), 32'h3);
    av(1'b0, 4'h4, 32'h0, q);
    chk("status", q, 32'hA);
    chk("seen pins", {30'h0, ev_seen, irq_seen}, 32'h1);
    lk(1'b1, 8'h84, 32'h104, q);
    repeat (2) @(posedge CLK_SYS);
    chk("disabled", pin(), 32'h1);
    chk("released pin", {30'h0, ev_seen, irq_seen}, 32'h3);
    lk(1'b1, 8'h84, 32'h3104, q);
    chk("reserved mode", {30'h0, mode_seen}, 32'h0);
    lk(1'b1, 8'h84, 32'h1104, q);
    chk("frame mode", {30'h0, mode_seen}, 32'h1);
    WAKE_REQ <= 1'b1;
    repeat (6) @(posedge CLK_SYS);
    chk("woken", {30'h0, mode_seen}, 32'h0);
    conclude();
  end
endmodule
